// *** card_csc_irq_and_window_enable.v ***
// card status-change interrupt routing, source enables and window enables
//
// What this block does
// R1: bits 7-4 of the irq config register pick the status-change destination and reset to 0000.
// R2: with route 0000 and the diagnostic bit set, status changes go to the pci interrupt alone.
// R3: with route 0000 and the diagnostic bit clear, the pci interrupt is used only if the pci route bit is 1.
// R4: route 0001 drives host irq line 1 and route 0010 drives the system management interrupt.
// R5: routes 1011, 1100 and 1101 drive host lines 11, 12 and 13, nonzero codes other than 0010 naming the line.
// R6: bit 3 enables a status change on any edge of either card detect line, reset 0.
// R7: bit 2 enables a status change on a rising edge of card ready, reset 0.
// R8: bit 1 enables a status change on a card battery warning, reset 0.
// R9: bit 0 enables a status change on battery dead or the card status pin, reset 0.
// R10: a card window whose enable bit is 0 never acknowledges a bus cycle.
// R11: the window enable register resets to all zeros.
// R12: window enable bit 7 enables io window 1 and bit 6 enables io window 0.
// R13: window enable bit 5 reads 0 and ignores writes.
// R14: window enable bits 4-0 enable memory windows 4-0.
// R15: an enabled source sets its flag, cleared by a read or by writing 1 depending on clear mode.
// R16: a flag reads 0 while its source enable is clear.
// R17: the chosen destination stays asserted while any enabled flag is set.
`timescale 1ns/1ps
`include "status_change_defines.vh"

module card_csc_irq_and_window_enable (
    input  wire        clk_sys,
    input  wire        rst_n,
    // register access
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // global settings held elsewhere
    input  wire        diag_pci_route,
    input  wire        pci_route_enable,
    input  wire        clear_by_write,
    // card signals
    input  wire        card_detect_a,
    input  wire        card_detect_b,
    input  wire        card_ready,
    input  wire        battery_warning,
    input  wire        card_status_pin,
    // window hit requests from the address decoders
    input  wire [1:0]  io_window_hit,
    input  wire [4:0]  mem_window_hit,
    output wire        window_ack,
    output wire [1:0]  io_window_enable,
    output wire [4:0]  mem_window_enable,
    // interrupt destinations
    output reg         pci_irq,
    output reg  [15:0] host_irq,
    output reg         system_management_interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // decoding used by both the write and read paths
    function sel;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    wire [7:0] irq_cfg;
    wire [7:0] win_en;
    wire       cfg_wr = reg_wr & sel(reg_addr, `OFS_IRQ_CONFIG);
    wire       win_wr = reg_wr & sel(reg_addr, `OFS_WINDOW_ENABLE);
    wire       sts_wr = reg_wr & sel(reg_addr, `OFS_STATUS_CHANGE);
    wire       sts_rd = reg_rd & sel(reg_addr, `OFS_STATUS_CHANGE);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    sc_reg_byte #(
        .RESET_VAL  (`RST_IRQ_CONFIG),
        .WRITE_MASK (8'hff)
    ) u_irq_cfg (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (reg_wdata),
        .q       (irq_cfg)
    ); // [R1] [R6] [R7] [R8] [R9]

    // the mask keeps the reserved bit stuck at zero
    sc_reg_byte #(
        .RESET_VAL  (`RST_WINDOW_ENABLE),
        .WRITE_MASK (`WIN_WRITE_MASK)
    ) u_win_en (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (win_wr),
        .wr_data (reg_wdata),
        .q       (win_en)
    ); // [R11] [R13]

    wire [3:0] route = irq_cfg[`ROUTE_HI:`ROUTE_LO];
    wire [3:0] src_en = {irq_cfg[`BIT_CD_EN], irq_cfg[`BIT_READY_EN],
                         irq_cfg[`BIT_BATWARN_EN], irq_cfg[`BIT_BATDEAD_EN]};

    ////////////////////////////////////////////////////////////////////////
    // window enables gate acknowledgement of decoded cycles
    assign io_window_enable  = {win_en[`BIT_IOWIN1], win_en[`BIT_IOWIN0]}; // [R12]
    assign mem_window_enable = win_en[`MEMWIN_HI:`MEMWIN_LO];                // [R14]
    assign window_ack = |(io_window_hit & io_window_enable) |
                        |(mem_window_hit & mem_window_enable);               // [R10]

    ////////////////////////////////////////////////////////////////////////
    // previous values of the card lines for edge detection
    reg cd_a_r;
    reg cd_b_r;
    reg ready_r;
    reg batwarn_r;
    reg card_status_pin_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cd_a_r    <= 1'b0;
            cd_b_r    <= 1'b0;
            ready_r   <= 1'b0;
            batwarn_r <= 1'b0;
            card_status_pin_r  <= 1'b0;
        end else begin
            cd_a_r    <= card_detect_a;
            cd_b_r    <= card_detect_b;
            ready_r   <= card_ready;
            batwarn_r <= battery_warning;
            card_status_pin_r  <= card_status_pin;
        end
    end

    // the first sample after reset may show a false card-detect edge;
    // software clears it at init anyway
    wire [3:0] src_event;
    assign src_event[3] = (card_detect_a ^ cd_a_r) | (card_detect_b ^ cd_b_r); // [R6]
    assign src_event[2] = card_ready & ~ready_r;                                 // [R7]
    assign src_event[1] = battery_warning & ~batwarn_r;                          // [R8]
    assign src_event[0] = card_status_pin & ~card_status_pin_r;                           // [R9]

    ////////////////////////////////////////////////////////////////////////
    // sticky flags; a new event beats a clear in the same cycle
    reg  [3:0] flag_r;
    reg  [3:0] flag_nxt;
    wire [3:0] flag_vis = flag_r & src_en; // [R16]
    wire [3:0] clr_mask = clear_by_write ? (sts_wr ? reg_wdata[3:0] : 4'h0)
                                         : (sts_rd ? 4'hf : 4'h0);

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SOURCES; gi = gi + 1) begin : g_flag
            always @* begin
                if (src_event[gi] & src_en[gi]) begin
                    flag_nxt[gi] = 1'b1;
                end else if (clr_mask[gi] | ~src_en[gi]) begin
                    flag_nxt[gi] = 1'b0;
                end else begin
                    flag_nxt[gi] = flag_r[gi];
                end
            end // [R15]
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is registered
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_STATUS_CHANGE: begin
                    reg_rdata <= {4'h0, flag_vis};
                end
                `OFS_IRQ_CONFIG: begin
                    reg_rdata <= irq_cfg;
                end
                `OFS_WINDOW_ENABLE: begin
                    reg_rdata <= win_en;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt routing held while any enabled flag stays set
    wire pending = |flag_vis; // [R17]

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pci_irq                     <= 1'b0;
            host_irq                    <= 16'h0000;
            system_management_interrupt <= 1'b0;
        end else begin
            pci_irq  <= pending & (route == `ROUTE_NONE) &
                        (diag_pci_route | pci_route_enable); // [R2] [R3]
            system_management_interrupt <= pending & (route == `ROUTE_SMI); // [R4]
            // line number equals the code; code 2 is the smi, not a line
            host_irq <= (pending && route != `ROUTE_NONE && route != `ROUTE_SMI)
                        ? (16'h0001 << route) : 16'h0000; // [R4] [R5]
        end
    end

endmodule

// *** status_change_defines.vh ***
// constants for the card status-change and window enable register block
`ifndef STATUS_CHANGE_DEFINES_VH
`define STATUS_CHANGE_DEFINES_VH

// register offsets within the socket register space
`define OFS_STATUS_CHANGE      8'h04
`define OFS_IRQ_CONFIG         8'h05
`define OFS_WINDOW_ENABLE      8'h06

// reset values
`define RST_IRQ_CONFIG         8'h00
`define RST_WINDOW_ENABLE      8'h00

// irq configuration fields
`define ROUTE_HI               7
`define ROUTE_LO               4
`define BIT_CD_EN              3
`define BIT_READY_EN           2
`define BIT_BATWARN_EN         1
`define BIT_BATDEAD_EN         0

// routing codes
`define ROUTE_NONE             4'h0
`define ROUTE_IRQ1             4'h1
`define ROUTE_SMI              4'h2

// window enable fields
`define BIT_IOWIN1             7
`define BIT_IOWIN0             6
`define BIT_WIN_RESERVED_BIT           5
`define MEMWIN_HI              4
`define MEMWIN_LO              0
`define WIN_WRITE_MASK         8'hdf

// widths
`define NUM_IRQ_LINES          16
`define NUM_SOURCES            4

`endif

// *** sc_reg_byte.v ***
// one byte-wide register with write mask and reset value
`timescale 1ns/1ps

module sc_reg_byte #(
    parameter [7:0] RESET_VAL  = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hff
) (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output reg  [7:0] q
);

    // masked bits keep their reset value forever, so reserved bits read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= (wr_data & WRITE_MASK) | (q & ~WRITE_MASK);
        end
    end

endmodule

// *** card_irq_win_properties.sv ***
// assertions on the ports of the irq routing and window enable block
`timescale 1ns/1ps

module card_irq_win_checker (
    input wire        clk_sys,
    input wire        rst_n,
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire [1:0]  io_window_hit,
    input wire [4:0]  mem_window_hit,
    input wire        window_ack,
    input wire [1:0]  io_window_enable,
    input wire [4:0]  mem_window_enable,
    input wire [15:0] host_irq,
    input wire        system_management_interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // decoded window access and enables, shared by several checks
    wire       wr_win = reg_wr && reg_addr == 8'h06;
    wire [6:0] en     = {io_window_enable, mem_window_enable};
    ////////////////////////////////////////////////////////////////////////
    a_ack_gate: assert property (window_ack == |({io_window_hit, mem_window_hit} & en))
        else $error("ack mismatch");
    a_win_reset: assert property ($rose(rst_n) |-> en == 7'h00)
        else $error("window reset");
    a_win_write: assert property (wr_win |=> en == {$past(reg_wdata[7:6]), $past(reg_wdata[4:0])})
        else $error("window write");
    a_win_hold: assert property (!wr_win |=> $stable(en))
        else $error("window drift");
    a_win_read: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == {$past(en[6:5]), 1'b0, $past(en[4:0])})
        else $error("window read");
    a_cfg_read: assert property ((reg_wr && reg_addr == 8'h05) ##2 (reg_rd && reg_addr == 8'h05) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("config read");
    a_host_legal: assert property ($onehot0(host_irq) && !host_irq[0] && !host_irq[2])
        else $error("host lines");
    a_mgmt_alone: assert property (system_management_interrupt |-> host_irq == 16'h0000)
        else $error("mgmt with host");
endmodule

bind card_csc_irq_and_window_enable card_irq_win_checker i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .io_window_hit(io_window_hit),
    .mem_window_hit(mem_window_hit), .window_ack(window_ack), .host_irq(host_irq),
    .io_window_enable(io_window_enable), .mem_window_enable(mem_window_enable),
    .system_management_interrupt(system_management_interrupt));

// *** card_model.sv ***
// behavioural card: detect a/b, ready, battery warning, status pin (bits 4..0)
`timescale 1ns/1ps

module card_model (
    input  wire       clk_sys,
    output reg  [4:0] lines
);
    // card absent, not ready, battery good
    initial lines = 5'h00;
    // detect lines toggle; the rest pulse high for two cycles, only the rise counts
    task ev(input integer s);
        begin
            @(posedge clk_sys);
            lines <= lines ^ (5'h10 >> s);
            repeat (2) @(posedge clk_sys);
            lines <= lines & 5'h18;
        end
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the status-change routing and window enable block
`timescale 1ns/1ps

module tb_top;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg         wr_s = 1'b0;
    reg         rd_s = 1'b0;
    reg  [7:0]  wdata = 8'h00;
    reg         diag = 1'b0;
    reg         pci_en = 1'b0;
    reg         cbw = 1'b0;
    reg  [6:0]  hit = 7'h00;
    wire [7:0]  rdata;
    wire        ack;
    wire [6:0]  en;
    wire [17:0] irq;
    wire [4:0]  card;
    integer     errors = 0;
    integer     check_count = 0;
    integer     i;
    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;
    card_model i_card (.clk_sys(clk_sys), .lines(card));
    card_csc_irq_and_window_enable i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(addr),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wdata), .reg_rdata(rdata),
        .diag_pci_route(diag), .pci_route_enable(pci_en), .clear_by_write(cbw),
        .card_detect_a(card[4]), .card_detect_b(card[3]), .card_ready(card[2]),
        .battery_warning(card[1]), .card_status_pin(card[0]), .io_window_hit(hit[6:5]),
        .mem_window_hit(hit[4:0]), .window_ack(ack), .io_window_enable(en[6:5]),
        .mem_window_enable(en[4:0]), .pci_irq(irq[17]), .host_irq(irq[15:0]),
        .system_management_interrupt(irq[16]));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [17:0] g, input [17:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // strobes are one-cycle pulses; read data is taken the cycle after
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            {wr_s, addr, wdata} <= {1'b1, a, d};
            @(posedge clk_sys);
            wr_s <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk_sys);
            {rd_s, addr} <= {1'b1, a};
            @(posedge clk_sys);
            rd_s <= 1'b0;
            @(negedge clk_sys);
            chk(rdata, e);
        end
    endtask
    // one card event, then clear the flag the way the current mode wants
    task fire(input integer s, input [7:0] cfg, input [17:0] e, input [7:0] st);
        begin
            wr(8'h05, cfg);
            i_card.ev(s);
            @(negedge clk_sys) chk(irq, e);
            rdc(8'h04, st);
            if (cbw)
                wr(8'h04, 8'h0f);
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys) chk(irq, 18'h0);
        end
    endtask
    task t_reset;
        begin
            rdc(8'h05, 8'h00);
            rdc(8'h06, 8'h00);
            wr(8'h05, 8'hd5);
            rdc(8'h05, 8'hd5);
        end
    endtask
    task t_windows;
        begin
            wr(8'h06, 8'hff);
            rdc(8'h06, 8'hdf);
            chk(en, 7'h7f);
            wr(8'h06, 8'h8a);
            for (i = 0; i < 8; i = i + 1) begin
                @(posedge clk_sys) hit <= (i == 7) ? 7'h00 : 7'h01 << i;
                @(negedge clk_sys) chk(ack, (7'h4a >> i) & 7'h01);
            end
        end
    endtask
    // every listed route code, both detect lines, both clear modes
    task t_routes;
        reg [27:0] codes;
        reg [3:0]  c;
        begin
            codes = 28'h123bcdf;
            for (i = 0; i < 7; i = i + 1) begin
                c = codes[4 * i +: 4];
                @(posedge clk_sys) cbw <= i[0];
                fire(i % 2, {c, 4'h8}, (c == 4'h2) ? 18'h10000 : 18'h1 << c, 8'h08);
            end
        end
    endtask
    task t_sources;
        begin
            fire(2, 8'h1f, 18'h2, 8'h04);
            fire(3, 8'h1f, 18'h2, 8'h02);
            fire(4, 8'h1f, 18'h2, 8'h01);
            fire(2, 8'h18, 18'h0, 8'h00);
        end
    endtask
    task t_pci;
        begin
            @(posedge clk_sys) diag <= 1'b1;
            fire(0, 8'h08, 18'h20000, 8'h08);
            @(posedge clk_sys) diag <= 1'b0;
            fire(1, 8'h08, 18'h0, 8'h08);
            @(posedge clk_sys) pci_en <= 1'b1;
            fire(0, 8'h08, 18'h20000, 8'h08);
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", errors, check_count);
            if (errors == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_windows;
        t_routes;
        t_sources;
        t_pci;
        finish_test;
    end
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #50000;
        errors = errors + 1;
        finish_test;
    end
endmodule
